// file: verilog/pactl_pkg.sv
// Package for the port A I/O control block: register map, reset values, field positions
package pactl_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] PIN_LEVEL_OFS    = 4'h0;
  localparam logic [3:0] DRIVEN_VALUE_OFS = 4'h4;
  localparam logic [3:0] DIRECTION_OFS    = 4'h8;
  localparam logic [3:0] ANALOG_SEL_OFS   = 4'hC;
  // Low byte-address bits that must be zero for a word access
  localparam int         ADDR_LSB         = 2;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int          PORT_W          = 8;
  localparam logic [7:0]  DIRECTION_RST   = 8'hFF;
  localparam logic [7:0]  DRIVEN_RST      = 8'h00;
  // Pins 0..3 and 5 analog after reset, pin 4 digital
  localparam logic [7:0]  ANALOG_MASK     = 8'h2F;
  localparam logic [7:0]  ANALOG_SEL_RST  = 8'h2F;
  localparam logic [7:0]  OSC_PINS_MASK   = 8'hC0;
  localparam int          OPEN_DRAIN_BIT  = 4;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : pactl_pkg

// file: verilog/pactl_port_a.sv
// Port A general-purpose I/O control with AXI4-Lite register access
//
// Behaviour
// - Eight bidirectional pins, each with direction, pin-level and driven-value bits.
// - Direction bit one turns the pin driver off; pin is an input.
// - Direction bit zero drives the pin with its driven-value latch bit.
// - Pin-level read returns pin levels; pin-level write updates the driven-value latch.
// - Driven-value register reads and writes the stored latch value directly.
// - Bits 6 and 7 read zero in all three registers unless freed from oscillator.
// - Oscillator selection from configuration decides whether pins 6 and 7 are I/O.
// - Analog-select control chooses analog or digital use of pins 0..3 and 5.
// - After reset pins 0..3 and 5 are analog reading zero; pin 4 digital.
// - Pin 4 output is open-drain, pulling low only; others push-pull.
// - Direction bits drive output enables even for analog-selected pins.
// - Pin 4 shares timer0 external clock input and comparator 1 output.
// - Pins 0..5 may be comparator inputs or outputs per comparator control.
// - An enabled peripheral takes over its shared pin from general I/O.
// - Direction register resets to all ones on every reset.
// - Each port is operated through its own three registers; this is port A.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module pactl_port_a #(
  parameter int PORT_W = pactl_pkg::PORT_W
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Configuration and peripheral sharing
  input  wire logic              osc_pins_free,
  input  wire logic [PORT_W-1:0] periph_own,
  input  wire logic [PORT_W-1:0] periph_out,
  input  wire logic [PORT_W-1:0] periph_oe,
  // Pins
  input  wire logic [PORT_W-1:0] pa_pin_in,
  output logic [PORT_W-1:0]      pa_pin_out,
  output logic [PORT_W-1:0]      pa_pin_oe,
  // Peripheral inputs from pins
  output logic                   timer0_ext_clock_in,
  output logic [PORT_W-1:0]      pa_digital_in
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] latch_q;
  logic [PORT_W-1:0] ansel_q;
  logic [PORT_W-1:0] sync1_q;
  logic [PORT_W-1:0] sync2_q;
  logic [3:0]        awaddr_q;
  logic              aw_have_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              w_have_q;
  logic              wr_fire;
  logic [PORT_W-1:0] io_mask;
  logic [PORT_W-1:0] wr_byte;
  logic              resp_done;
  logic              rd_take;

  // Mask of bits that are real I/O under the present oscillator choice
  // Stored bits 6 and 7 survive under the mask, so freeing the pins restores them
  // bits 6 7 gated
  assign io_mask = osc_pins_free ? {PORT_W{1'b1}} : ~pactl_pkg::OSC_PINS_MASK[PORT_W-1:0];

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_byte = wstrb_q[0] ? wdata_q[PORT_W-1:0] : {PORT_W{1'b0}};
  // The master taking the response frees both write slots
  assign resp_done = s_axi_bvalid && s_axi_bready;
  // A new read is taken only after the previous data has been handed over
  assign rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  // Strobe for a write hitting a given offset with the low byte lane enabled
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs, input logic en);
    hit = en && (addr == ofs);
  endfunction : hit

  // Pin levels as software and peripherals see them: analog and oscillator bits read zero
  function automatic logic [PORT_W-1:0] pin_view(input logic [PORT_W-1:0] lvl,
                                                 input logic [PORT_W-1:0] ana,
                                                 input logic [PORT_W-1:0] mask);
    pin_view = lvl & ~ana & mask;
  endfunction : pin_view

  // Every register is one aligned word; low byte-address bits must be zero
  function automatic logic word_aligned(input logic [3:0] addr);
    word_aligned = (addr[pactl_pkg::ADDR_LSB-1:0] == '0);
  endfunction : word_aligned

  // ****************************************
  // Input synchroniser
  // ****************************************
  // Only the second stage feeds any logic; the first may still be settling
  // two stage sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= {PORT_W{1'b0}};
      sync2_q <= {PORT_W{1'b0}};
    end else begin
      sync1_q <= pa_pin_in;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // Direction register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= pactl_pkg::DIRECTION_RST[PORT_W-1:0];
    end else if (hit(awaddr_q, pactl_pkg::DIRECTION_OFS, wr_fire && wstrb_q[0])) begin
      dir_q <= wr_byte;
    end
  end

  // ****************************************
  // Driven-value latch
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= pactl_pkg::DRIVEN_RST[PORT_W-1:0];
    end else if (hit(awaddr_q, pactl_pkg::PIN_LEVEL_OFS, wr_fire && wstrb_q[0]) ||
                 hit(awaddr_q, pactl_pkg::DRIVEN_VALUE_OFS, wr_fire && wstrb_q[0])) begin
      latch_q <= wr_byte;
    end
  end

  // ****************************************
  // Analog select
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ansel_q <= pactl_pkg::ANALOG_SEL_RST[PORT_W-1:0];
    end else if (hit(awaddr_q, pactl_pkg::ANALOG_SEL_OFS, wr_fire && wstrb_q[0])) begin
      ansel_q <= wr_byte & pactl_pkg::ANALOG_MASK[PORT_W-1:0];
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // per pin control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_pin_out <= {PORT_W{1'b0}};
      pa_pin_oe  <= {PORT_W{1'b0}};
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        if (!io_mask[i]) begin
          // Oscillator owns the pin; port logic stays off it
          pa_pin_out[i] <= 1'b0;
          pa_pin_oe[i]  <= 1'b0;
        end else if (periph_own[i]) begin
          if (i == pactl_pkg::OPEN_DRAIN_BIT) begin
            pa_pin_out[i] <= 1'b0;
            pa_pin_oe[i]  <= periph_oe[i] && !periph_out[i];
          end else begin
            pa_pin_out[i] <= periph_out[i];
            pa_pin_oe[i]  <= periph_oe[i];
          end
        end else if (i == pactl_pkg::OPEN_DRAIN_BIT) begin
          pa_pin_out[i] <= 1'b0;
          pa_pin_oe[i]  <= !dir_q[i] && !latch_q[i];
        end else begin
          pa_pin_out[i] <= latch_q[i];
          pa_pin_oe[i]  <= !dir_q[i];
        end
      end
    end
  end

  // ****************************************
  // Digital inputs to peripherals
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_digital_in <= {PORT_W{1'b0}};
    end else begin
      pa_digital_in <= pin_view(sync2_q, ansel_q, io_mask);
    end
  end

  // Timer tap follows pin 4 whoever drives it, so the timer can count its own output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer0_ext_clock_in <= 1'b0;
    end else begin
      timer0_ext_clock_in <= sync2_q[pactl_pkg::OPEN_DRAIN_BIT];
    end
  end

  // ****************************************
  // AXI4-Lite write address slot
  // ****************************************
  // One address is held until its response is taken; awready is a single-cycle pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      awaddr_q      <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
      end else if (resp_done) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite write data slot
  // ****************************************
  // Only byte lane 0 carries register bits; other lanes are taken and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q     <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end else if (resp_done) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite write response
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pactl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      // A misaligned address matches no register, so it is refused with nothing written
      s_axi_bresp  <= word_aligned(awaddr_q) ? pactl_pkg::RESP_OKAY : pactl_pkg::RESP_SLVERR;
    end else if (resp_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read handshake
  // ****************************************
  // own register set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (rd_take) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read data
  // ****************************************
  // Captured with the address, so data stands unchanged while rvalid waits for rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pactl_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rresp <= pactl_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      case (s_axi_araddr)
        pactl_pkg::PIN_LEVEL_OFS: begin
          s_axi_rdata[PORT_W-1:0] <= pin_view(sync2_q, ansel_q, io_mask);
        end
        pactl_pkg::DRIVEN_VALUE_OFS: begin
          s_axi_rdata[PORT_W-1:0] <= latch_q & io_mask;
        end
        pactl_pkg::DIRECTION_OFS: begin
          s_axi_rdata[PORT_W-1:0] <= dir_q & io_mask;
        end
        pactl_pkg::ANALOG_SEL_OFS: begin
          s_axi_rdata[PORT_W-1:0] <= ansel_q;
        end
        default: begin
          s_axi_rresp <= pactl_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

endmodule : pactl_port_a

// file: bench/pactl_pin_model.sv
// Pad model: resolves each port A pad from the block's drive and an outside source
module pactl_pin_model (
  // Block side
  input  wire logic [7:0] pa_pin_out,
  input  wire logic [7:0] pa_pin_oe,
  // Outside source and pads
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pa_pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pa_pin_in = (pa_pin_oe & pa_pin_out) | (~pa_pin_oe & ext_val);
endmodule : pactl_pin_model

// file: bench/pactl_port_a_checker.sv
// Concurrent checks on the port A block's bus and pin ports
module pactl_port_a_checker #(
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  // Pins
  input wire logic              osc_pins_free,
  input wire logic [PORT_W-1:0] pa_pin_in,
  input wire logic [PORT_W-1:0] pa_pin_out,
  input wire logic [PORT_W-1:0] pa_pin_oe,
  input wire logic              timer0_ext_clock_in
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pipeline full of post-reset samples
  sequence settled_s; aresetn [*4]; endsequence
  sequence osc_held_s; !osc_pins_free [*2]; endsequence
  reset_oe_a: assert property ($rose(aresetn) |-> pa_pin_oe == '0)
    else $error("pin driver on after reset");
  osc_pins_a: assert property (osc_held_s |-> pa_pin_oe[7:6] == 2'b00)
    else $error("oscillator pin driven");
  open_drain_a: assert property (pa_pin_out[pactl_pkg::OPEN_DRAIN_BIT] == 1'b0)
    else $error("pin 4 driven high");
  sync_lag_a: assert property (settled_s |-> timer0_ext_clock_in == $past(pa_pin_in[4], 3))
    else $error("timer clock input lag wrong");
  aw_pulse_a: assert property (s_axi_awready |-> $past(s_axi_awvalid) ##1 !s_axi_awready)
    else $error("write address ready not a pulse");
  write_answer_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:2] s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  rdata_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7");
endmodule : pactl_port_a_checker

bind pactl_port_a pactl_port_a_checker #(.PORT_W(PORT_W)) i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .osc_pins_free, .pa_pin_in, .pa_pin_out, .pa_pin_oe,
  .timer0_ext_clock_in
);

// file: bench/pactl_port_a_tb.sv
// Self-checking bench for the port A I/O block
module pactl_port_a_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] PIN = pactl_pkg::PIN_LEVEL_OFS;
  localparam logic [3:0] DRV = pactl_pkg::DRIVEN_VALUE_OFS;
  localparam logic [3:0] DIR = pactl_pkg::DIRECTION_OFS;
  localparam logic [3:0] ANA = pactl_pkg::ANALOG_SEL_OFS;
  localparam logic [1:0] OK  = pactl_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pactl_pkg::RESP_SLVERR;
  logic aclk = 1'b0, aresetn, osc_pins_free = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer0_ext_clock_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] periph_own = 8'h00, periph_out = 8'h00, periph_oe = 8'h00, ext_val = 8'hff;
  logic [7:0] pa_pin_in, pa_pin_out, pa_pin_oe, pa_digital_in;
  int fails = 0, compares = 0;

  always #12.5 aclk = ~aclk;

  pactl_port_a i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_pins_free,
    .periph_own, .periph_out, .periph_oe, .pa_pin_in, .pa_pin_out, .pa_pin_oe, .timer0_ext_clock_in, .pa_digital_in);
  pactl_pin_model i_pins (.pa_pin_out, .pa_pin_oe, .ext_val, .pa_pin_in);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic rst();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : rst

  // Address and data offered together, each held until taken; only the watchdog ends a wait
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Pins need the synchroniser to fill before a read
  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask : settle

  initial begin
    rst();
    rd(DIR, 32'h0000_003f, OK);
    rd(PIN, 32'h0000_0010, OK);
    chk(32'(pa_digital_in), 32'h0000_0010);
    osc_pins_free <= 1'b1;
    @(posedge aclk);
    rd(DIR, 32'h0000_00ff, OK);
    chk(32'(pa_pin_oe), 32'h0000_0000);
    wr(PIN, 8'h5a);
    rd(DRV, 32'h0000_005a, OK);
    wr(DIR, 8'h00);
    settle();
    chk(32'(pa_pin_oe), 32'h0000_00ef);
    chk(32'(pa_pin_out), 32'h0000_004a);
    rd(PIN, 32'h0000_0050, OK);
    wr(ANA, 8'h00);
    settle();
    chk(32'(pa_digital_in), 32'h0000_005a);
    rd(PIN, 32'h0000_005a, OK);
    wr(DRV, 8'h00);
    settle();
    rd(PIN, 32'h0000_0000, OK);
    periph_own <= 8'h01;
    periph_out <= 8'h01;
    periph_oe <= 8'h01;
    settle();
    chk(32'(pa_pin_out & 8'h01), 32'h0000_0001);
    periph_oe <= 8'h00;
    settle();
    chk(32'(pa_pin_oe & 8'h01), 32'h0000_0000);
    rd(4'h2, 32'h0000_0000, ERR);
    wr(4'h1, 8'hff);
    chk(32'(resp), 32'(ERR));
    rst();
    rd(DIR, 32'h0000_00ff, OK);
    wr(DIR, 8'h2f);
    settle();
    chk(32'(pa_pin_oe), 32'h0000_00d0);
    finish_test();
  end

  // A run of this length needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge aclk);
    fails++;
    finish_test();
  end
endmodule : pactl_port_a_tb
